// [logic/lrc_defs.svh]
// constants for the limits and reset configuration block
`ifndef LRC_DEFS_SVH
`define LRC_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LRC_ADDR_CMD     8'h14
`define LRC_ADDR_LIMITS  8'h16

// ----------------------------------------------------------------
// limits_and_reset_config fields
// ----------------------------------------------------------------
`define LRC_B_RESTART_AFTER_FAULT      0
`define LRC_B_RSTIND     1
`define LRC_B_FORCE      2
`define LRC_F_TPW_LO     4
`define LRC_F_TPW_HI     5
`define LRC_F_IPK_LO     6
`define LRC_F_IPK_HI     7
`define LRC_LIM_RST      8'hE3
`define LRC_LIM_WMASK    8'hF3

// ----------------------------------------------------------------
// command register mode bits
// ----------------------------------------------------------------
`define LRC_B_MODE_HI    6
`define LRC_B_MODE_LO    7
`define LRC_CMD_MODE_RST 2'h3
`define LRC_MODE_IDX_HI  0
`define LRC_MODE_IDX_LO  1

// ----------------------------------------------------------------
// misc
// ----------------------------------------------------------------
`define LRC_BYTE_ZERO    8'h00
`define LRC_FAULT_NUM    2

`endif

// [logic/lrc_pkg.sv]
// types for the limits and reset configuration block
package lrc_pkg;
    typedef enum logic [1:0] {
        LRC_ST_RUN,
        LRC_ST_HALTED,
        LRC_ST_RESTART
    } lrc_state_t;
endpackage

// [logic/lrc_sync.sv]
// three-flop input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module lrc_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level_q
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_d;

    if (WIDTH < 1) begin : g_chk
        $error("lrc_sync: WIDTH must be at least 1");
    end

    // ----------------------------------------------------------------
    // filter
    // ----------------------------------------------------------------
    // a change counts only once stages two and three agree
    always_comb begin
        level_d = level_q;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                level_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s1_q    <= '0;
            s2_q    <= '0;
            s3_q    <= '0;
            level_q <= '0;
        end else begin
            s1_q    <= async_in;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= level_d;
        end
    end
endmodule
`default_nettype wire

// [logic/lrc_top.sv]
// limits and reset configuration register with fault re-arm control
`timescale 1ns/10ps
`default_nettype none
`include "lrc_defs.svh"
module lrc_top
    import lrc_pkg::*;
#(
    parameter int FAULTS = `LRC_FAULT_NUM
) (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata_q,
    input  wire logic       mode_sel,
    input  wire logic       thermal_shutdown,
    input  wire logic       output_short_circuit,
    output logic            forced_pulse_mode_q,
    output logic      [1:0] peak_current_limit_q,
    output logic      [1:0] thermal_prewarn_threshold_q,
    output logic            converter_off_q,
    output logic            restart_pulse_q,
    output logic            regs_reset_q
);
    logic [7:0]       lim_q;
    logic [7:0]       lim_d;
    logic [1:0]       cmd_mode_q;
    logic [1:0]       cmd_mode_d;
    logic [7:0]       rdata_d;
    logic             regs_reset_d;
    logic             fpm_d;
    logic [1:0]       ipk_d;
    logic [1:0]       tpw_d;
    lrc_state_t       st_q;
    lrc_state_t       st_d;
    logic             off_d;
    logic             restart_d;
    logic [FAULTS-1:0] fault_lvl;
    logic             fault_any;
    logic             wr_lim;
    logic             wr_cmd;
    logic             force_wr;

    if (FAULTS != `LRC_FAULT_NUM) begin : g_chk
        $error("lrc_top: FAULTS must match the two fault inputs");
    end

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ----------------------------------------------------------------
    // fault inputs
    // ----------------------------------------------------------------
    // analog comparators are asynchronous to clk_sys
    lrc_sync #(
        .WIDTH (FAULTS)
    ) u_sync (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .async_in ({output_short_circuit, thermal_shutdown}),
        .level_q  (fault_lvl)
    );

    assign fault_any = |fault_lvl;
    assign wr_lim    = reg_wr && hit(reg_addr, `LRC_ADDR_LIMITS);
    assign wr_cmd    = reg_wr && hit(reg_addr, `LRC_ADDR_CMD);
    assign force_wr  = wr_lim && reg_wdata[`LRC_B_FORCE];

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    always_comb begin
        lim_d        = lim_q;
        cmd_mode_d   = cmd_mode_q;
        regs_reset_d = 1'b0;
        if (force_wr) begin
            // other data bits of a forcing write are discarded on purpose
            lim_d        = `LRC_LIM_RST;
            cmd_mode_d   = `LRC_CMD_MODE_RST;
            regs_reset_d = 1'b1;
        end else if (wr_lim) begin
            // force bit never stored, so it self-clears
            lim_d = reg_wdata & `LRC_LIM_WMASK;
        end else if (wr_cmd) begin
            cmd_mode_d[`LRC_MODE_IDX_HI] = reg_wdata[`LRC_B_MODE_HI];
            cmd_mode_d[`LRC_MODE_IDX_LO] = reg_wdata[`LRC_B_MODE_LO];
        end
    end

    always_comb begin
        rdata_d = `LRC_BYTE_ZERO;
        if (hit(reg_addr, `LRC_ADDR_LIMITS)) begin
            rdata_d = lim_q;
        end else if (hit(reg_addr, `LRC_ADDR_CMD)) begin
            rdata_d[`LRC_B_MODE_HI] = cmd_mode_q[`LRC_MODE_IDX_HI];
            rdata_d[`LRC_B_MODE_LO] = cmd_mode_q[`LRC_MODE_IDX_LO];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lim_q        <= `LRC_LIM_RST;
            cmd_mode_q   <= `LRC_CMD_MODE_RST;
            regs_reset_q <= 1'b0;
            reg_rdata_q  <= `LRC_BYTE_ZERO;
        end else begin
            lim_q        <= lim_d;
            cmd_mode_q   <= cmd_mode_d;
            regs_reset_q <= regs_reset_d;
            reg_rdata_q  <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // analog settings and mode
    // ----------------------------------------------------------------
    // limit fields taken from next value so they land with the write edge; mode uses the stored value
    always_comb begin
        ipk_d = lim_d[`LRC_F_IPK_HI:`LRC_F_IPK_LO];
        tpw_d = lim_d[`LRC_F_TPW_HI:`LRC_F_TPW_LO];
        if (mode_sel) begin
            fpm_d = cmd_mode_q[`LRC_MODE_IDX_HI];
        end else begin
            fpm_d = cmd_mode_q[`LRC_MODE_IDX_LO];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            peak_current_limit_q        <= 2'((`LRC_LIM_RST >> `LRC_F_IPK_LO));
            thermal_prewarn_threshold_q <= 2'((`LRC_LIM_RST >> `LRC_F_TPW_LO));
            forced_pulse_mode_q         <= 1'b0;
        end else begin
            peak_current_limit_q        <= ipk_d;
            thermal_prewarn_threshold_q <= tpw_d;
            forced_pulse_mode_q         <= fpm_d;
        end
    end

    // ----------------------------------------------------------------
    // fault re-arm state machine
    // ----------------------------------------------------------------
    // re-arm waits for the fault to go away, else it would loop
    always_comb begin
        st_d = st_q;
        case (st_q)
            LRC_ST_RUN: begin
                if (fault_any) begin
                    st_d = LRC_ST_HALTED;
                end
            end
            LRC_ST_HALTED: begin
                if (!fault_any && lim_q[`LRC_B_RESTART_AFTER_FAULT]) begin
                    st_d = LRC_ST_RESTART;
                end
            end
            LRC_ST_RESTART: begin
                st_d = LRC_ST_RUN;
            end
            default: begin
                st_d = LRC_ST_RUN;
            end
        endcase
        off_d     = (st_d == LRC_ST_HALTED);
        restart_d = (st_d == LRC_ST_RESTART);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_q            <= LRC_ST_RUN;
            converter_off_q <= 1'b0;
            restart_pulse_q <= 1'b0;
        end else begin
            st_q            <= st_d;
            converter_off_q <= off_d;
            restart_pulse_q <= restart_d;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_MODE_HI: assert property (@(posedge clk_sys) disable iff (!nrst)
        mode_sel && !wr_cmd && !force_wr
        |=> forced_pulse_mode_q == cmd_mode_q[`LRC_MODE_IDX_HI])
        else $error("forced mode wrong with mode signal high");

    AST_MODE_LO: assert property (@(posedge clk_sys) disable iff (!nrst)
        !mode_sel && !wr_cmd && !force_wr
        |=> forced_pulse_mode_q == cmd_mode_q[`LRC_MODE_IDX_LO])
        else $error("forced mode wrong with mode signal low");

    AST_STAY_OFF: assert property (@(posedge clk_sys) disable iff (!nrst)
        st_q == LRC_ST_HALTED && !lim_q[`LRC_B_RESTART_AFTER_FAULT] && !wr_lim
        |=> converter_off_q && !restart_pulse_q)
        else $error("converter left off state without re-arm");

    AST_RESTART_AFTER_FAULT: assert property (@(posedge clk_sys) disable iff (!nrst)
        st_q == LRC_ST_HALTED && !fault_any && lim_q[`LRC_B_RESTART_AFTER_FAULT]
        |=> restart_pulse_q && !converter_off_q ##1 !restart_pulse_q)
        else $error("re-arm did not issue one restart pulse");

    AST_FAULT_OFF: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(fault_any) && st_q == LRC_ST_RUN |=> converter_off_q)
        else $error("fault did not switch converter off");

    AST_KEEP_REGS: assert property (@(posedge clk_sys) disable iff (!nrst)
        restart_pulse_q && !$past(reg_wr) |-> $stable(lim_q) && !regs_reset_q)
        else $error("restart disturbed programmed registers");

    AST_FORCE_DEF: assert property (@(posedge clk_sys) disable iff (!nrst)
        force_wr |=> lim_q == `LRC_LIM_RST && regs_reset_q
        && cmd_mode_q == `LRC_CMD_MODE_RST)
        else $error("forced reset did not reload defaults");

    AST_IND_SET: assert property (@(posedge clk_sys) disable iff (!nrst)
        regs_reset_q |-> lim_q[`LRC_B_RSTIND])
        else $error("reset indicator not set after register reset");

    AST_FORCE_ZERO: assert property (@(posedge clk_sys) disable iff (!nrst)
        !lim_q[`LRC_B_FORCE] && !reg_rdata_q[`LRC_B_FORCE])
        else $error("force bit not self cleared");

    AST_FIELDS: assert property (@(posedge clk_sys) disable iff (!nrst)
        wr_lim && !force_wr
        |=> peak_current_limit_q == $past(reg_wdata[`LRC_F_IPK_HI:`LRC_F_IPK_LO])
        && thermal_prewarn_threshold_q == $past(reg_wdata[`LRC_F_TPW_HI:`LRC_F_TPW_LO]))
        else $error("threshold fields did not follow write");

    AST_FIELD_TIE: assert property (@(posedge clk_sys) disable iff (!nrst)
        peak_current_limit_q == lim_q[`LRC_F_IPK_HI:`LRC_F_IPK_LO]
        && thermal_prewarn_threshold_q == lim_q[`LRC_F_TPW_HI:`LRC_F_TPW_LO])
        else $error("field outputs differ from register");
endmodule
`default_nettype wire

// [test/tb_lrc_top.sv]
// self-checking bench for the limits and reset configuration block
`timescale 1ns/10ps
`default_nettype none
`include "lrc_defs.svh"
module tb_lrc_top;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic       clk_sys              = 1'b0;
    logic       nrst                 = 1'b0;
    logic       reg_wr               = 1'b0;
    logic [7:0] reg_addr             = 8'h00;
    logic [7:0] reg_wdata            = 8'h00;
    logic       mode_sel             = 1'b0;
    logic       thermal_shutdown     = 1'b0;
    logic       output_short_circuit = 1'b0;
    logic [7:0] reg_rdata_q;
    logic       forced_pulse_mode_q;
    logic [1:0] peak_current_limit_q;
    logic [1:0] thermal_prewarn_threshold_q;
    logic       converter_off_q;
    logic       restart_pulse_q;
    logic       regs_reset_q;
    int         miscompares          = 0;
    int         total_checks         = 0;
    int         cycles               = 0;
    int         seed                 = 33;
    logic [7:0] d;
    logic [7:0] r;
    logic       bad;

    lrc_top lrc_top_i (
        .clk_sys                     (clk_sys),
        .nrst                        (nrst),
        .reg_wr                      (reg_wr),
        .reg_addr                    (reg_addr),
        .reg_wdata                   (reg_wdata),
        .reg_rdata_q                 (reg_rdata_q),
        .mode_sel                    (mode_sel),
        .thermal_shutdown            (thermal_shutdown),
        .output_short_circuit        (output_short_circuit),
        .forced_pulse_mode_q         (forced_pulse_mode_q),
        .peak_current_limit_q        (peak_current_limit_q),
        .thermal_prewarn_threshold_q (thermal_prewarn_threshold_q),
        .converter_off_q             (converter_off_q),
        .restart_pulse_q             (restart_pulse_q),
        .regs_reset_q                (regs_reset_q)
    );

    always #50 clk_sys = ~clk_sys;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic give_verdict;
        if (miscompares == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // run is a few hundred cycles; ceiling leaves wide margin
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            $display("ERROR %0t run did not finish", $time);
            give_verdict();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // returns at the falling edge after the write edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_sys);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = v;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(negedge clk_sys);
        reg_addr = a;
        @(negedge clk_sys);
        chk(reg_rdata_q, exp, what);
    endtask

    function automatic logic exp_mode(input logic [7:0] cmd, input logic ms);
        return ms ? cmd[`LRC_B_MODE_HI] : cmd[`LRC_B_MODE_LO];
    endfunction

    // fault path goes through a synchroniser, so wait a bounded while
    task automatic wait_off;
        int n;
        n = 0;
        while (converter_off_q !== 1'b1 && n < 12) begin
            @(negedge clk_sys);
            n++;
        end
        chk({7'h00, converter_off_q}, 8'h01, "halt on fault");
    endtask

    task automatic wait_restart;
        int n;
        n = 0;
        while (restart_pulse_q !== 1'b1 && n < 12) begin
            @(negedge clk_sys);
            n++;
        end
        chk({7'h00, restart_pulse_q}, 8'h01, "restart pulse");
        chk({7'h00, converter_off_q}, 8'h00, "off released");
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        nrst = 1'b1;
        rdchk(8'h16, 8'hE3, "limits default");
        chk({6'h00, peak_current_limit_q}, 8'h03, "peak default");
        chk({6'h00, thermal_prewarn_threshold_q}, 8'h02, "thresh default");
        for (int i = 0; i < 16; i++) begin
            d = {i[3:0], 4'($random(seed)) & 4'hB};
            wr(8'h16, d);
            chk({6'h00, peak_current_limit_q}, {6'h00, d[7:6]}, "peak field");
            chk({6'h00, thermal_prewarn_threshold_q}, {6'h00, d[5:4]}, "thresh");
            rdchk(8'h16, d & `LRC_LIM_WMASK, "limits readback");
        end
        for (int i = 0; i < 8; i++) begin
            d = {i[1:0], 6'($random(seed))};
            mode_sel = i[2];
            wr(8'h14, d);
            @(negedge clk_sys);
            chk({7'h00, forced_pulse_mode_q}, {7'h00, exp_mode(d, i[2])}, "mode");
            rdchk(8'h14, d & 8'hC0, "cmd readback");
        end
        // unmapped places take nothing and read zero
        r = 8'h20 | 8'($random(seed));
        wr(r, 8'hFF);
        rdchk(r, 8'h00, "unmapped read");
        wr(8'h15, 8'hFF);
        rdchk(8'h15, 8'h00, "reserved read");
        wr(8'h14, 8'h00);
        wr(8'h16, 8'h50);
        wr(8'h16, 8'h04);
        chk({7'h00, regs_reset_q}, 8'h01, "force pulse");
        chk({4'h0, peak_current_limit_q, thermal_prewarn_threshold_q}, 8'h0E, "force");
        @(negedge clk_sys);
        chk({7'h00, regs_reset_q}, 8'h00, "force pulse end");
        rdchk(8'h16, 8'hE3, "limits after force");
        rdchk(8'h14, 8'hC0, "cmd after force");
        // halt without re-arm, then re-arm by a later write
        wr(8'h16, 8'h90);
        thermal_shutdown = 1'b1;
        wait_off();
        thermal_shutdown = 1'b0;
        bad = 1'b0;
        repeat (20) begin
            @(negedge clk_sys);
            if (converter_off_q !== 1'b1 || restart_pulse_q !== 1'b0) bad = 1'b1;
        end
        chk({7'h00, bad}, 8'h00, "stays off");
        wr(8'h16, 8'h91);
        wait_restart();
        rdchk(8'h16, 8'h91, "kept after restart");
        output_short_circuit = 1'b1;
        wait_off();
        output_short_circuit = 1'b0;
        wait_restart();
        rdchk(8'h16, 8'h91, "kept after short");
        // second reset in mid-run reloads defaults
        nrst = 1'b0;
        repeat (3) @(negedge clk_sys);
        nrst = 1'b1;
        rdchk(8'h16, 8'hE3, "limits after reset");
        give_verdict();
    end
endmodule
`default_nettype wire
